/* quad_pot_pkg.sv */
// Shared constants and types for the quad potentiometer command decoder.
package quad_pot_pkg;
  localparam logic [3:0] ADDR_FIXED      = 4'h5;
  localparam logic [3:0] OP_RD_WIPER     = 4'h9;
  localparam logic [3:0] OP_WR_WIPER     = 4'hA;
  localparam logic [3:0] OP_RD_STORED    = 4'hB;
  localparam logic [3:0] OP_WR_STORED    = 4'hC;
  localparam logic [3:0] OP_LOAD_WIPER   = 4'hD;
  localparam logic [3:0] OP_SAVE_WIPER   = 4'hE;
  localparam logic [3:0] OP_GANG_LOAD    = 4'h1;
  localparam logic [3:0] OP_GANG_SAVE    = 4'h8;
  localparam logic [3:0] OP_STEP         = 4'h2;
  localparam logic [3:0] BIT_ACK         = 4'h8;
  localparam logic [7:0] WIPER_RESET     = 8'h00;
  localparam logic [7:0] STORED_RESET    = 8'h00;
  localparam logic [7:0] WIPER_MAX       = 8'hFF;
  localparam logic [7:0] WIPER_MIN       = 8'h00;
  localparam int         MCLK_MHZ        = 125;
  localparam int         NV_WRITE_TIME_US = 5000;
  localparam int         NV_WRITE_CYCLES = NV_WRITE_TIME_US * MCLK_MHZ;
  localparam int         NV_CNT_W        = 20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_STEP,
    ST_HOLD
  } frame_state_t;
endpackage

/* quad_pot_command_decoder.sv */
// Two-wire command decoder with wiper and stored setting registers for four pots.
`timescale 1ns/10ps
module quad_pot_command_decoder #(
  parameter int unsigned NV_WRITE_CYCLES = quad_pot_pkg::NV_WRITE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       dev_addr_bit3,
  input  wire logic       dev_addr_bit2,
  input  wire logic       dev_addr_bit1,
  input  wire logic       dev_addr_bit0,
  output logic [7:0]      wiper_pos0,
  output logic [7:0]      wiper_pos1,
  output logic [7:0]      wiper_pos2,
  output logic [7:0]      wiper_pos3,
  output logic            nv_busy
);
  localparam logic [quad_pot_pkg::NV_CNT_W-1:0] NV_LOAD = quad_pot_pkg::NV_CNT_W'(NV_WRITE_CYCLES - 1);

  // Link domain: the data line is captured on the serial clock itself.
  // It stays stable for a whole bit, so the core reads it once the synchronised clock rise is seen.
  logic link_bit_q;
  always_ff @(posedge scl) begin
    link_bit_q <= sda_i;
  end

  logic       scl_s1_q, scl_s2_q, scl_s3_q;
  logic       sda_s1_q, sda_s2_q, sda_s3_q;
  logic [3:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      scl_s1_q <= scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      pin_s1_q <= {dev_addr_bit3, dev_addr_bit2, dev_addr_bit1, dev_addr_bit0};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise   = scl_s2_q & ~scl_s3_q;
  assign scl_fall   = ~scl_s2_q & scl_s3_q;
  assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_seen  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  function automatic logic instr_valid(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    unique case (b[7:4])
      quad_pot_pkg::OP_RD_WIPER,
      quad_pot_pkg::OP_WR_WIPER,
      quad_pot_pkg::OP_STEP:         ok = (b[3:2] == 2'h0);
      quad_pot_pkg::OP_GANG_LOAD,
      quad_pot_pkg::OP_GANG_SAVE:    ok = (b[1:0] == 2'h0);
      quad_pot_pkg::OP_RD_STORED,
      quad_pot_pkg::OP_WR_STORED,
      quad_pot_pkg::OP_LOAD_WIPER,
      quad_pot_pkg::OP_SAVE_WIPER:   ok = 1'b1;
      default:                       ok = 1'b0;
    endcase
    return ok;
  endfunction

  quad_pot_pkg::frame_state_t      state_q, state_d;
  logic [3:0]                      cnt_q, cnt_d;
  logic [7:0]                      sh_q, sh_d;
  logic [7:0]                      instr_q, instr_d;
  logic                            oe_q, oe_d;
  logic                            pend_q, pend_d;
  logic                            busy_q, busy_d;
  logic [quad_pot_pkg::NV_CNT_W-1:0] nv_cnt_q, nv_cnt_d;
  logic [7:0]                      wiper_q [4];
  logic [7:0]                      wiper_d [4];
  logic [7:0]                      stored_q [16];
  logic [7:0]                      stored_d [16];
  logic                            ack_ok;
  logic [1:0]                      pot;

  always_comb begin
    ack_ok = 1'b0;
    unique case (state_q)
      quad_pot_pkg::ST_ADDR:  ack_ok = (sh_q == {quad_pot_pkg::ADDR_FIXED, pin_s2_q}) && !busy_q;
      quad_pot_pkg::ST_INSTR: ack_ok = instr_valid(sh_q);
      quad_pot_pkg::ST_WDATA: ack_ok = 1'b1;
      default:                ack_ok = 1'b0;
    endcase
  end

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    instr_d  = instr_q;
    oe_d     = oe_q;
    pend_d   = pend_q;
    busy_d   = busy_q;
    nv_cnt_d = nv_cnt_q;
    wiper_d  = wiper_q;
    stored_d = stored_q;
    pot      = instr_q[1:0];
    // Programming time runs down on the core clock.
    if (busy_q) begin
      if (nv_cnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        nv_cnt_d = nv_cnt_q - 1'b1;
      end
    end
    if (stop_seen) begin
      state_d = quad_pot_pkg::ST_IDLE;
      oe_d    = 1'b0;
      if (pend_q) begin
        pend_d   = 1'b0;
        busy_d   = 1'b1;
        nv_cnt_d = NV_LOAD;
      end
    end else if (start_seen) begin
      state_d = quad_pot_pkg::ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else begin
      // The pin is driven low only; the line is released for a one.
      if (scl_fall) begin
        oe_d = (cnt_q == quad_pot_pkg::BIT_ACK) ? ack_ok
             : (state_q == quad_pot_pkg::ST_RDATA) && !sh_q[7];
      end
      if (scl_rise && state_q == quad_pot_pkg::ST_STEP) begin
        if (link_bit_q && wiper_q[pot] != quad_pot_pkg::WIPER_MAX) begin
          wiper_d[pot] = wiper_q[pot] + 8'h01;
        end else if (!link_bit_q && wiper_q[pot] != quad_pot_pkg::WIPER_MIN) begin
          wiper_d[pot] = wiper_q[pot] - 8'h01;
        end
      end else if (scl_rise && state_q != quad_pot_pkg::ST_IDLE && state_q != quad_pot_pkg::ST_HOLD) begin
        if (cnt_q != quad_pot_pkg::BIT_ACK) begin
          sh_d  = {sh_q[6:0], link_bit_q};
          cnt_d = cnt_q + 4'h1;
        end else begin
          cnt_d   = 4'h0;
          state_d = quad_pot_pkg::ST_HOLD;
          unique case (state_q)
            quad_pot_pkg::ST_ADDR: begin
              if (ack_ok) begin
                state_d = quad_pot_pkg::ST_INSTR;
              end
            end
            quad_pot_pkg::ST_INSTR: begin
              instr_d = sh_q;
              if (ack_ok) begin
                unique case (sh_q[7:4])
                  quad_pot_pkg::OP_RD_WIPER: begin
                    sh_d    = wiper_q[sh_q[1:0]];
                    state_d = quad_pot_pkg::ST_RDATA;
                  end
                  quad_pot_pkg::OP_RD_STORED: begin
                    sh_d    = stored_q[sh_q[3:0]];
                    state_d = quad_pot_pkg::ST_RDATA;
                  end
                  quad_pot_pkg::OP_WR_WIPER,
                  quad_pot_pkg::OP_WR_STORED: begin
                    state_d = quad_pot_pkg::ST_WDATA;
                  end
                  quad_pot_pkg::OP_LOAD_WIPER: begin
                    wiper_d[sh_q[1:0]] = stored_q[sh_q[3:0]];
                  end
                  quad_pot_pkg::OP_SAVE_WIPER: begin
                    stored_d[sh_q[3:0]] = wiper_q[sh_q[1:0]];
                    pend_d              = 1'b1;
                  end
                  quad_pot_pkg::OP_GANG_LOAD: begin
                    for (int i = 0; i < 4; i++) begin
                      wiper_d[i] = stored_q[{sh_q[3:2], 2'(i)}];
                    end
                  end
                  quad_pot_pkg::OP_GANG_SAVE: begin
                    for (int i = 0; i < 4; i++) begin
                      stored_d[{sh_q[3:2], 2'(i)}] = wiper_q[i];
                    end
                    pend_d = 1'b1;
                  end
                  quad_pot_pkg::OP_STEP: begin
                    state_d = quad_pot_pkg::ST_STEP;
                  end
                  default: begin
                    state_d = quad_pot_pkg::ST_HOLD;
                  end
                endcase
              end
            end
            quad_pot_pkg::ST_WDATA: begin
              if (instr_q[7:4] == quad_pot_pkg::OP_WR_STORED) begin
                stored_d[instr_q[3:0]] = sh_q;
                pend_d                 = 1'b1;
              end else begin
                wiper_d[instr_q[1:0]] = sh_q;
              end
            end
            default: begin
              state_d = quad_pot_pkg::ST_HOLD;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q  <= quad_pot_pkg::ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      instr_q  <= 8'h00;
      oe_q     <= 1'b0;
      pend_q   <= 1'b0;
      busy_q   <= 1'b0;
      nv_cnt_q <= '0;
      for (int i = 0; i < 4; i++) begin
        wiper_q[i] <= quad_pot_pkg::WIPER_RESET;
      end
      for (int i = 0; i < 16; i++) begin
        stored_q[i] <= quad_pot_pkg::STORED_RESET;
      end
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      instr_q  <= instr_d;
      oe_q     <= oe_d;
      pend_q   <= pend_d;
      busy_q   <= busy_d;
      nv_cnt_q <= nv_cnt_d;
      wiper_q  <= wiper_d;
      stored_q <= stored_d;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe     = oe_q;
  assign nv_busy    = busy_q;
  assign wiper_pos0 = wiper_q[0];
  assign wiper_pos1 = wiper_q[1];
  assign wiper_pos2 = wiper_q[2];
  assign wiper_pos3 = wiper_q[3];
endmodule

/* quad_pot_props.sv */
// Port checks for the quad potentiometer command decoder.
`timescale 1ns/10ps
module quad_pot_props #(
  parameter int unsigned NV_WRITE_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       dev_addr_bit3,
  input wire logic       dev_addr_bit2,
  input wire logic       dev_addr_bit1,
  input wire logic       dev_addr_bit0,
  input wire logic [7:0] wiper_pos0,
  input wire logic [7:0] wiper_pos1,
  input wire logic [7:0] wiper_pos2,
  input wire logic [7:0] wiper_pos3,
  input wire logic       nv_busy
);
  int unsigned busy_q;
  int unsigned busy_d;
  always_comb busy_d = nv_busy ? busy_q + 1 : 0;
  always_ff @(posedge mclk) busy_q <= rst ? 0 : busy_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  drive_low_a: assert property (!sda_o) else $error("data line driven high");
  busy_quiet_a: assert property (nv_busy |-> !sda_oe) else $error("ack while busy");
  busy_start_a: assert property ($rose(nv_busy) |-> scl && sda_i) else $error("busy before stop");
  busy_len_a: assert property ($fell(nv_busy) |-> busy_q == NV_WRITE_CYCLES) else $error("busy length");
  oe_rise_a: assert property ($rose(sda_oe) |-> !scl) else $error("drive began with clock high");
  oe_hold_a: assert property (scl && $changed(sda_oe) |-> !sda_oe) else $error("drive moved in high");
  wiper_quiet_a: assert property (!scl [*6] |=> $stable({wiper_pos0, wiper_pos1, wiper_pos2, wiper_pos3}))
    else $error("wiper moved without clock");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !nv_busy && !sda_oe && wiper_pos3 == 8'h00)
    else $error("reset state wrong");
  cover property ($rose(nv_busy));
  cover property ($rose(sda_oe));
  cover property ($changed(wiper_pos1));
endmodule

/* two_wire_master.sv */
// Behavioural two-wire bus master that clocks the link only inside frames.
`timescale 1ns/10ps
module two_wire_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Frames start 3 ns off the core clock's rising edge, so no link edge lands in a core sampling step.
  task automatic start_c();
    #3;
    sda_m = 1'b1;
    #40 scl = 1'b1;
    #80 sda_m = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask
  // The clock rise of a stop also counts as a low step in a step frame.
  task automatic stop_c();
    sda_m = 1'b0;
    #40 scl = 1'b1;
    #80 sda_m = 1'b1;
    #85;
  endtask
  task automatic bit_c(input logic b, output logic s);
    sda_m = b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic byte_c(input logic [7:0] d, input logic a9, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
      q[i] = s;
    end
    bit_c(a9, s);
    ack = ~s;
  endtask
endmodule

/* quad_pot_command_decoder_tb.sv */
// Self-checking bench for the quad potentiometer command decoder.
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module quad_pot_command_decoder_tb;
  localparam int unsigned NV_CYC = 400;
  logic       mclk;
  logic       rst;
  logic [3:0] pins;
  logic       sda_o;
  logic       sda_oe;
  logic       nv_busy;
  logic [7:0] w0, w1, w2, w3, q;
  logic       a;
  wire        scl;
  wire        sda_m;
  wire        sda;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  // The line is pulled up, so a released line reads high.
  assign sda = sda_m & (~sda_oe | sda_o);
  two_wire_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
  quad_pot_command_decoder #(.NV_WRITE_CYCLES(NV_CYC)) uut (.mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr_bit3(pins[3]), .dev_addr_bit2(pins[2]), .dev_addr_bit1(pins[1]),
    .dev_addr_bit0(pins[0]), .wiper_pos0(w0), .wiper_pos1(w1), .wiper_pos2(w2), .wiper_pos3(w3), .nv_busy(nv_busy));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] ins, input logic ak);
    m.start_c();
    m.byte_c({4'h5, pins}, 1'b1, q, a);
    `CHK("addr ack", 1'b1, a)
    m.byte_c(ins, 1'b1, q, a);
    `CHK("instr ack", ak, a)
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 600 && nv_busy === 1'b1; n++) @(posedge mclk);
    `CHK("busy end", 1'b0, nv_busy)
  endtask
  task automatic t_stored();
    cmd(8'hC9, 1'b1);
    m.byte_c(8'hA5, 1'b1, q, a);
    `CHK("data ack", 1'b1, a)
    `CHK("busy early", 1'b0, nv_busy)
    m.stop_c();
    `CHK("busy", 1'b1, nv_busy)
    m.start_c();
    m.byte_c({4'h5, pins}, 1'b1, q, a);
    `CHK("busy refusal", 1'b0, a)
    m.stop_c();
    wait_idle();
    cmd(8'hB9, 1'b1);
    m.byte_c(8'hFF, 1'b0, q, a);
    `CHK("read stored", 8'hA5, q)
    m.stop_c();
    $display("test stored done");
  endtask
  task automatic t_step();
    cmd(8'h20, 1'b1);
    for (int i = 0; i < 5; i++) m.bit_c(i != 0, a);
    m.stop_c();
    `CHK("steps", 8'h03, w0)
    cmd(8'h23, 1'b1);
    repeat (2) m.bit_c(1'b1, a);
    m.stop_c();
    `CHK("steps pot3", 8'h01, w3)
    `CHK("step busy", 1'b0, nv_busy)
    $display("test step done");
  endtask
  task automatic t_xfer();
    cmd(8'hD9, 1'b1);
    `CHK("load wiper", 8'hA5, w1)
    m.stop_c();
    cmd(8'h88, 1'b1);
    m.stop_c();
    `CHK("gang save busy", 1'b1, nv_busy)
    wait_idle();
    cmd(8'h10, 1'b1);
    m.stop_c();
    `CHK("gang slot0", 32'h00000000, {w0, w1, w2, w3})
    cmd(8'h18, 1'b1);
    m.stop_c();
    `CHK("gang slot2", 32'h03A50001, {w0, w1, w2, w3})
    cmd(8'hED, 1'b1);
    m.stop_c();
    `CHK("save busy", 1'b1, nv_busy)
    wait_idle();
    cmd(8'hBD, 1'b1);
    m.byte_c(8'hFF, 1'b0, q, a);
    `CHK("saved wiper", 8'hA5, q)
    m.stop_c();
    $display("test transfer done");
  endtask
  task automatic t_refuse();
    m.start_c();
    m.byte_c({4'h5, ~pins}, 1'b1, q, a);
    `CHK("other pins", 1'b0, a)
    m.stop_c();
    m.start_c();
    m.byte_c({4'h4, pins}, 1'b1, q, a);
    `CHK("fixed nibble", 1'b0, a)
    m.stop_c();
    cmd(8'h30, 1'b0);
    m.stop_c();
    cmd(8'h24, 1'b0);
    m.stop_c();
    `CHK("unchanged", 32'h03A50001, {w0, w1, w2, w3})
    @(posedge mclk);
    pins <= 4'h3;
    repeat (6) @(posedge mclk);
    cmd(8'h20, 1'b1);
    m.stop_c();
    `CHK("new pins", 8'h02, w0)
    $display("test refusal done");
  endtask
  initial begin
    rst = 1'b1;
    pins = 4'hA;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("reset wiper", 8'h00, w0)
    t_stored();
    t_step();
    t_xfer();
    t_refuse();
    complete_run();
  end
endmodule
bind quad_pot_command_decoder quad_pot_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (.mclk(mclk), .rst(rst),
  .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr_bit3(dev_addr_bit3),
  .dev_addr_bit2(dev_addr_bit2), .dev_addr_bit1(dev_addr_bit1), .dev_addr_bit0(dev_addr_bit0),
  .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1), .wiper_pos2(wiper_pos2), .wiper_pos3(wiper_pos3),
  .nv_busy(nv_busy));
